// >>> core/plc_cell.sv
// Programmable logic cell: two logic arrays and an 8-bit datapath.
`timescale 1ns/100ps
// Operation
// - Each logic array takes twelve inputs spread over eight product terms.
// - A product term ANDs one to twelve inputs, each true or inverted.
// - Each output ORs one to eight terms; any term feeds any output.
// - Each array output is selectable as combinational or registered.
// - The cell holds two independent logic arrays beside one datapath.
// - An 8-bit ALU does one operation per clock and feeds conditions.
// - Accumulators are ALU sources, ALU destinations and compare operands.
// - Data registers are only ALU and compare sources, never ALU results.
// - Two four-byte FIFOs load or capture working registers and results.
// - Bus master reads and writes the four working registers any time.
// - Eight stored 16-bit words; the addressed one sets this cycle's function.
// - ALU does increment, decrement, add, subtract, AND, OR, XOR, pass.
// - Shift left, shift right, nibble swap and OR mask follow the ALU.
// - Two maskable compares pick operands from accumulators and data registers.
// - Zero, ones and overflow conditions join compares; a subset drives out.
// - Compare 0, carry and shift results chain to neighbouring cells.
// - The top bit for arithmetic and shifting is configurable.
// - One CRC or pseudo random sequence step per clock, any polynomial.
// - Wider CRC chains feedback into neighbours or through the logic arrays.
module plc_cell (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [4:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [plc_pkg::DW-1:0] bus_wdata,
  output logic [plc_pkg::DW-1:0] bus_rdata,
  input wire logic [2:0] cfg_addr,
  input wire logic [1:0] fifo_dir_in,
  input wire logic [1:0] fifo_src_acc,
  input wire logic [1:0] cmp0_sel,
  input wire logic [1:0] cmp1_sel,
  input wire logic [plc_pkg::DW-1:0] cmp0_mask,
  input wire logic [plc_pkg::DW-1:0] cmp1_mask,
  input wire logic [2:0] msb_sel,
  input wire logic [plc_pkg::DW-1:0] or_mask,
  input wire logic [plc_pkg::DW-1:0] crc_poly,
  input wire logic [plc_pkg::NCOND-1:0] cond_en,
  input wire logic chain_en,
  input wire logic shift_in,
  input wire logic chain_eq_in,
  input wire logic chain_lt_in,
  input wire logic chain_carry_in,
  input wire logic chain_fb_in,
  output logic [plc_pkg::NCOND-1:0] cond_out,
  output logic chain_eq_out,
  output logic chain_lt_out,
  output logic chain_carry_out,
  output logic chain_fb_out,
  output logic shift_out,
  output logic [1:0] fifo_empty,
  output logic [1:0] fifo_full,
  input wire logic [plc_pkg::PLA_IN-1:0] pla0_in,
  input wire logic [plc_pkg::PLA_PT*plc_pkg::PLA_IN-1:0] pla0_pt_true,
  input wire logic [plc_pkg::PLA_PT*plc_pkg::PLA_IN-1:0] pla0_pt_comp,
  input wire logic [plc_pkg::PLA_OUT*plc_pkg::PLA_PT-1:0] pla0_or_sel,
  input wire logic [plc_pkg::PLA_OUT-1:0] pla0_reg_sel,
  output logic [plc_pkg::PLA_OUT-1:0] pla0_out,
  input wire logic [plc_pkg::PLA_IN-1:0] pla1_in,
  input wire logic [plc_pkg::PLA_PT*plc_pkg::PLA_IN-1:0] pla1_pt_true,
  input wire logic [plc_pkg::PLA_PT*plc_pkg::PLA_IN-1:0] pla1_pt_comp,
  input wire logic [plc_pkg::PLA_OUT*plc_pkg::PLA_PT-1:0] pla1_or_sel,
  input wire logic [plc_pkg::PLA_OUT-1:0] pla1_reg_sel,
  output logic [plc_pkg::PLA_OUT-1:0] pla1_out
);
  import plc_pkg::*;
  logic [DW-1:0] acc0_r, acc1_r, dat0_r, dat1_r;
  logic [CFG_W-1:0] cfg_ram_r [CFG_WORDS];
  logic [CFG_W-1:0] cfg;
  logic [DW-1:0] op_a, op_b;
  logic [DW-1:0] alu_res;
  logic alu_cout, alu_ovf;
  logic [DW-1:0] msb_mask, sh_res;
  logic sh_out;
  logic crc_fb;
  logic [DW-1:0] crc_res, dp_res;
  logic [1:0] dest;
  logic [DW-1:0] c0x, c0y, c1x, c1y;
  logic eq0, lt0, eq1, lt1;
  logic [NCOND-1:0] cond;
  logic [DW-1:0] f_head [2], f_din [2];
  logic [1:0] f_push, f_pop, f_dp_push, f_dp_pop, f_bus_wr, f_bus_rd, f_has;
  logic [DW-1:0] rdata_r;
  logic [NCOND-1:0] cond_r;
  logic eq_out_r, lt_out_r, carry_out_r, fb_out_r, shift_out_r;
  logic [1:0] empty_r, full_r;
  genvar f;

  // ****************************************
  // Logic arrays
  // ****************************************
  plc_logic_array u_pla0 (
    .clk(clk),
    .rst_b(rst_b),
    .in_bits(pla0_in),
    .pt_true(pla0_pt_true),
    .pt_comp(pla0_pt_comp),
    .or_sel(pla0_or_sel),
    .reg_sel(pla0_reg_sel),
    .out_bits(pla0_out)
  );
  plc_logic_array u_pla1 (
    .clk(clk),
    .rst_b(rst_b),
    .in_bits(pla1_in),
    .pt_true(pla1_pt_true),
    .pt_comp(pla1_pt_comp),
    .or_sel(pla1_or_sel),
    .reg_sel(pla1_reg_sel),
    .out_bits(pla1_out)
  );

  // ****************************************
  // Configuration store
  // ****************************************
  assign cfg = cfg_ram_r[cfg_addr];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < CFG_WORDS; i++) begin
        cfg_ram_r[i] <= RST_CFG;
      end
    end else if (bus_wr && bus_addr[4]) begin
      if (bus_addr[0]) begin
        cfg_ram_r[bus_addr[3:1]][15:8] <= bus_wdata;
      end else begin
        cfg_ram_r[bus_addr[3:1]][7:0] <= bus_wdata;
      end
    end
  end

  // ****************************************
  // Operand selection and ALU
  // ****************************************
  function automatic logic [DW-1:0] pick(input logic [1:0] s, input logic [DW-1:0] a0,
      input logic [DW-1:0] a1, input logic [DW-1:0] d0, input logic [DW-1:0] d1);
    case (s)
      2'h0: pick = a0;
      2'h1: pick = a1;
      2'h2: pick = d0;
      default: pick = d1;
    endcase
  endfunction

  assign op_a = pick(cfg[CF_SRCA +: 2], acc0_r, acc1_r, dat0_r, dat1_r);
  assign op_b = pick(cfg[CF_SRCB +: 2], acc0_r, acc1_r, dat0_r, dat1_r);

  plc_alu u_alu (
    .func(cfg[CF_FUNC +: 3]),
    .op_a(op_a),
    .op_b(op_b),
    .carry_in(chain_en & chain_carry_in),
    .msb(msb_sel),
    .res(alu_res),
    .carry_out(alu_cout),
    .ovf(alu_ovf)
  );

  // ****************************************
  // Shift, swap, CRC and mask stage
  // ****************************************
  assign msb_mask = 8'hff >> (3'h7 - msb_sel);
  always_comb begin
    sh_res = alu_res;
    sh_out = 1'b0;
    case (cfg[CF_SHIFT +: 2])
      SH_LEFT: begin
        sh_res = {alu_res[DW-2:0], shift_in} & msb_mask;
        sh_out = alu_res[msb_sel];
      end
      SH_RIGHT: begin
        sh_res = alu_res >> 1;
        sh_res[msb_sel] = shift_in;
        sh_out = alu_res[0];
      end
      SH_SWAP: sh_res = {alu_res[3:0], alu_res[7:4]};
      default: sh_res = alu_res;
    endcase
  end

  // Chained feedback lets a lower cell fold in the top bit of a wider register.
  assign crc_fb = chain_en ? chain_fb_in : (op_a[msb_sel] ^ shift_in);
  assign crc_res = ({op_a[DW-2:0], 1'b0} ^ (crc_fb ? crc_poly : 8'h00)) & msb_mask;
  assign dp_res = (cfg[CF_CRC] ? crc_res : sh_res) | or_mask;
  assign dest = cfg[CF_DEST +: 2];

  // ****************************************
  // FIFOs
  // ****************************************
  assign f_dp_push = {cfg[CF_F1_PUSH], cfg[CF_F0_PUSH]};
  assign f_dp_pop[0] = cfg[CF_D0_LOAD] | (dest == DS_FIFO);
  assign f_dp_pop[1] = cfg[CF_D1_LOAD] | (dest == DS_FIFO);
  assign f_bus_wr[0] = bus_wr && (bus_addr == OFS_FIFO0);
  assign f_bus_wr[1] = bus_wr && (bus_addr == OFS_FIFO1);
  assign f_bus_rd[0] = bus_rd && (bus_addr == OFS_FIFO0);
  assign f_bus_rd[1] = bus_rd && (bus_addr == OFS_FIFO1);
  assign f_din[0] = fifo_dir_in[0] ? bus_wdata : (fifo_src_acc[0] ? acc0_r : dp_res);
  assign f_din[1] = fifo_dir_in[1] ? bus_wdata : (fifo_src_acc[1] ? acc1_r : dp_res);

  generate
    for (f = 0; f < 2; f++) begin : g_fifo
      logic [DW-1:0] mem_r [FIFO_DEPTH];
      logic [1:0] wp_r;
      logic [1:0] rp_r;
      logic [2:0] cnt_r;
      // Input mode: bus fills, datapath drains. Output mode: the reverse.
      assign f_push[f] = (fifo_dir_in[f] ? f_bus_wr[f] : f_dp_push[f]) && (cnt_r != 3'h4);
      assign f_pop[f] = (fifo_dir_in[f] ? f_dp_pop[f] : f_bus_rd[f]) && (cnt_r != 3'h0);
      assign f_head[f] = mem_r[rp_r];
      assign f_has[f] = (cnt_r != 3'h0);
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          wp_r <= 2'h0;
          rp_r <= 2'h0;
          cnt_r <= 3'h0;
          for (int i = 0; i < FIFO_DEPTH; i++) begin
            mem_r[i] <= RST_REG;
          end
        end else begin
          if (f_push[f]) begin
            mem_r[wp_r] <= f_din[f];
            wp_r <= wp_r + 2'h1;
          end
          if (f_pop[f]) begin
            rp_r <= rp_r + 2'h1;
          end
          cnt_r <= cnt_r + {2'h0, f_push[f]} - {2'h0, f_pop[f]};
        end
      end
    end
  endgenerate

  // ****************************************
  // Working registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc0_r <= RST_REG;
      acc1_r <= RST_REG;
    end else begin
      if (dest == DS_ACC0) begin
        acc0_r <= dp_res;
      end else if (dest == DS_FIFO && fifo_dir_in[0] && f_has[0]) begin
        acc0_r <= f_head[0];
      end
      if (dest == DS_ACC1) begin
        acc1_r <= dp_res;
      end else if (dest == DS_FIFO && fifo_dir_in[1] && f_has[1]) begin
        acc1_r <= f_head[1];
      end
      // A bus write lands last and so wins over the datapath.
      if (bus_wr && bus_addr == OFS_ACC0) begin
        acc0_r <= bus_wdata;
      end
      if (bus_wr && bus_addr == OFS_ACC1) begin
        acc1_r <= bus_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dat0_r <= RST_REG;
      dat1_r <= RST_REG;
    end else begin
      if (cfg[CF_D0_LOAD] && fifo_dir_in[0] && f_has[0]) begin
        dat0_r <= f_head[0];
      end
      if (cfg[CF_D1_LOAD] && fifo_dir_in[1] && f_has[1]) begin
        dat1_r <= f_head[1];
      end
      if (bus_wr && bus_addr == OFS_DAT0) begin
        dat0_r <= bus_wdata;
      end
      if (bus_wr && bus_addr == OFS_DAT1) begin
        dat1_r <= bus_wdata;
      end
    end
  end

  // ****************************************
  // Bus read port
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= RST_REG;
    end else if (bus_rd) begin
      case (bus_addr)
        OFS_ACC0: rdata_r <= acc0_r;
        OFS_ACC1: rdata_r <= acc1_r;
        OFS_DAT0: rdata_r <= dat0_r;
        OFS_DAT1: rdata_r <= dat1_r;
        OFS_FIFO0: rdata_r <= f_has[0] ? f_head[0] : RST_REG;
        OFS_FIFO1: rdata_r <= f_has[1] ? f_head[1] : RST_REG;
        default: rdata_r <= RST_REG;
      endcase
    end
  end

  // ****************************************
  // Compares and conditions
  // ****************************************
  always_comb begin
    c0x = (cmp0_sel[1] ? acc0_r : (cmp0_sel[0] ? acc1_r : acc0_r)) & cmp0_mask;
    c0y = pick(cmp0_sel, dat0_r, dat1_r, acc1_r, dat1_r) & cmp0_mask;
    c1x = (cmp1_sel[1] ? acc0_r : (cmp1_sel[0] ? acc1_r : acc0_r)) & cmp1_mask;
    c1y = pick(cmp1_sel, dat0_r, dat1_r, acc1_r, dat1_r) & cmp1_mask;
    // The lower-order neighbour decides the tie when chained.
    eq0 = (c0x == c0y) && (!chain_en || chain_eq_in);
    lt0 = (c0x < c0y) || ((c0x == c0y) && chain_en && chain_lt_in);
    eq1 = (c1x == c1y);
    lt1 = (c1x < c1y);
    cond = {alu_ovf, (acc1_r == 8'hff), (acc0_r == 8'hff), (acc1_r == 8'h00),
      (acc0_r == 8'h00), lt1, eq1, lt0, eq0};
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cond_r <= '0;
      eq_out_r <= 1'b0;
      lt_out_r <= 1'b0;
      carry_out_r <= 1'b0;
      shift_out_r <= 1'b0;
      fb_out_r <= 1'b0;
    end else begin
      cond_r <= cond & cond_en;
      eq_out_r <= eq0;
      lt_out_r <= lt0;
      carry_out_r <= alu_cout;
      shift_out_r <= sh_out;
      fb_out_r <= crc_fb;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      empty_r <= 2'h3;
      full_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        empty_r[i] <= !f_has[i] ? !f_push[i] : (f_pop[i] && !f_push[i] &&
          (g_fifo_cnt(i) == 3'h1));
        full_r[i] <= (g_fifo_cnt(i) + {2'h0, f_push[i]} - {2'h0, f_pop[i]}) == 3'h4;
      end
    end
  end

  function automatic logic [2:0] g_fifo_cnt(input int i);
    g_fifo_cnt = (i == 0) ? g_fifo[0].cnt_r : g_fifo[1].cnt_r;
  endfunction

  // ****************************************
  // Outputs
  // ****************************************
  assign bus_rdata = rdata_r;
  assign cond_out = cond_r;
  assign chain_eq_out = eq_out_r;
  assign chain_lt_out = lt_out_r;
  assign chain_carry_out = carry_out_r;
  assign chain_fb_out = fb_out_r;
  assign shift_out = shift_out_r;
  assign fifo_empty = empty_r;
  assign fifo_full = full_r;
endmodule

// >>> core/plc_pkg.sv
// Shared constants for the programmable logic cell.
package plc_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int DW = 8;
  localparam int PLA_IN = 12;
  localparam int PLA_PT = 8;
  localparam int PLA_OUT = 4;
  localparam int CFG_WORDS = 8;
  localparam int CFG_W = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int NCOND = 9;
  // ****************************************
  // Register index map
  // ****************************************
  localparam logic [4:0] OFS_ACC0 = 5'h00;
  localparam logic [4:0] OFS_ACC1 = 5'h01;
  localparam logic [4:0] OFS_DAT0 = 5'h02;
  localparam logic [4:0] OFS_DAT1 = 5'h03;
  localparam logic [4:0] OFS_FIFO0 = 5'h04;
  localparam logic [4:0] OFS_FIFO1 = 5'h05;
  localparam logic [4:0] OFS_CFG_BASE = 5'h10;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [15:0] RST_CFG = 16'h0000;
  // ****************************************
  // Configuration word fields
  // ****************************************
  localparam int CF_FUNC = 0;
  localparam int CF_SRCA = 3;
  localparam int CF_SRCB = 5;
  localparam int CF_SHIFT = 7;
  localparam int CF_DEST = 9;
  localparam int CF_CRC = 11;
  localparam int CF_F0_PUSH = 12;
  localparam int CF_F1_PUSH = 13;
  localparam int CF_D0_LOAD = 14;
  localparam int CF_D1_LOAD = 15;
  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [2:0] FN_PASS = 3'h0;
  localparam logic [2:0] FN_INC = 3'h1;
  localparam logic [2:0] FN_DEC = 3'h2;
  localparam logic [2:0] FN_ADD = 3'h3;
  localparam logic [2:0] FN_SUB = 3'h4;
  localparam logic [2:0] FN_XOR = 3'h5;
  localparam logic [2:0] FN_AND = 3'h6;
  localparam logic [2:0] FN_OR = 3'h7;
  localparam logic [1:0] SH_NONE = 2'h0;
  localparam logic [1:0] SH_LEFT = 2'h1;
  localparam logic [1:0] SH_RIGHT = 2'h2;
  localparam logic [1:0] SH_SWAP = 2'h3;
  localparam logic [1:0] DS_NONE = 2'h0;
  localparam logic [1:0] DS_ACC0 = 2'h1;
  localparam logic [1:0] DS_ACC1 = 2'h2;
  localparam logic [1:0] DS_FIFO = 2'h3;
endpackage

// >>> core/plc_logic_array.sv
// Twelve-input, eight-term, four-output sum-of-products logic array.
`timescale 1ns/100ps
module plc_logic_array #(
  parameter int NIN = plc_pkg::PLA_IN,
  parameter int NPT = plc_pkg::PLA_PT,
  parameter int NOUT = plc_pkg::PLA_OUT
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [NIN-1:0] in_bits,
  input wire logic [NPT*NIN-1:0] pt_true,
  input wire logic [NPT*NIN-1:0] pt_comp,
  input wire logic [NOUT*NPT-1:0] or_sel,
  input wire logic [NOUT-1:0] reg_sel,
  output logic [NOUT-1:0] out_bits
);
  import plc_pkg::*;
  logic [NPT-1:0] pt;
  logic [NOUT-1:0] sum;
  logic [NOUT-1:0] sum_r;
  genvar p, o;
  // ****************************************
  // Product terms
  // ****************************************
  generate
    for (p = 0; p < NPT; p++) begin : g_pt
      logic [NIN-1:0] t;
      logic [NIN-1:0] c;
      assign t = pt_true[p*NIN +: NIN];
      assign c = pt_comp[p*NIN +: NIN];
      // A term with no input selected is unused and reads low.
      assign pt[p] = (|(t | c)) & (&((~t | in_bits) & (~c | ~in_bits)));
    end
    for (o = 0; o < NOUT; o++) begin : g_out
      assign sum[o] = |(pt & or_sel[o*NPT +: NPT]);
    end
  endgenerate
  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sum_r <= '0;
    end else begin
      sum_r <= sum;
    end
  end
  assign out_bits = (reg_sel & sum_r) | (~reg_sel & sum);
endmodule

// >>> core/plc_alu.sv
// Eight-function arithmetic and logic unit with a variable top bit.
`timescale 1ns/100ps
module plc_alu #(
  parameter int W = plc_pkg::DW
) (
  input wire logic [2:0] func,
  input wire logic [W-1:0] op_a,
  input wire logic [W-1:0] op_b,
  input wire logic carry_in,
  input wire logic [$clog2(W)-1:0] msb,
  output logic [W-1:0] res,
  output logic carry_out,
  output logic ovf
);
  import plc_pkg::*;
  logic [W-1:0] mask;
  logic [W-1:0] a;
  logic [W-1:0] b;
  logic [W:0] raw;
  logic sub;
  always_comb begin
    mask = {W{1'b1}} >> (W - 1 - int'(msb));
    a = op_a & mask;
    b = op_b & mask;
    sub = 1'b0;
    case (func)
      FN_INC: raw = {1'b0, a} + {{W{1'b0}}, 1'b1};
      FN_DEC: begin
        raw = {1'b0, a} - {{W{1'b0}}, 1'b1};
        sub = 1'b1;
      end
      FN_ADD: raw = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, carry_in};
      FN_SUB: begin
        raw = {1'b0, a} - {1'b0, b};
        sub = 1'b1;
      end
      FN_XOR: raw = {1'b0, a ^ b};
      FN_AND: raw = {1'b0, a & b};
      FN_OR: raw = {1'b0, a | b};
      default: raw = {1'b0, a};
    endcase
    res = raw[W-1:0] & mask;
    carry_out = raw[int'(msb) + 1];
    if (func == FN_ADD) begin
      ovf = (a[msb] == b[msb]) && (res[msb] != a[msb]);
    end else if (func == FN_SUB) begin
      ovf = (a[msb] != b[msb]) && (res[msb] != a[msb]);
    end else if (func == FN_INC || func == FN_DEC) begin
      ovf = (res[msb] != a[msb]) && (sub ? a[msb] : !a[msb]);
    end else begin
      ovf = 1'b0;
    end
  end
endmodule

// >>> bench/plc_cell_props.sv
// Port-level checks for the programmable logic cell.
`timescale 1ns/100ps
module plc_cell_props import plc_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [4:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [plc_pkg::DW-1:0] bus_rdata,
  input wire logic [1:0] fifo_dir_in,
  input wire logic [plc_pkg::NCOND-1:0] cond_en,
  input wire logic [plc_pkg::NCOND-1:0] cond_out,
  input wire logic [1:0] fifo_empty,
  input wire logic [1:0] fifo_full,
  input wire logic [plc_pkg::PLA_OUT*plc_pkg::PLA_PT-1:0] pla0_or_sel,
  input wire logic [plc_pkg::PLA_OUT-1:0] pla0_reg_sel,
  input wire logic [plc_pkg::PLA_OUT-1:0] pla0_out,
  input wire logic [plc_pkg::PLA_OUT*plc_pkg::PLA_PT-1:0] pla1_or_sel,
  input wire logic [plc_pkg::PLA_OUT-1:0] pla1_reg_sel,
  input wire logic [plc_pkg::PLA_OUT-1:0] pla1_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_unmapped_rd;
    bus_rd && bus_addr > OFS_FIFO1 && bus_addr < OFS_CFG_BASE;
  endsequence
  sequence s_fill_f0;
    fifo_dir_in[0] && fifo_empty[0] && bus_wr && bus_addr == OFS_FIFO0;
  endsequence
  AST_RST_VAL: assert property (
    $rose(rst_b) |-> cond_out == '0 && fifo_empty == 2'h3 && fifo_full == 2'h0)
    else $error("outputs not cleared by reset");
  AST_COND_MASK: assert property (
    (cond_out & ~$past(cond_en)) == '0) else $error("disabled condition driven");
  AST_FIFO_EXCL: assert property (
    (fifo_empty & fifo_full) == 2'h0) else $error("fifo empty and full together");
  AST_RD_HOLD: assert property (
    !bus_rd |=> $stable(bus_rdata)) else $error("read data moved without a read");
  AST_RD_UNMAPPED: assert property (
    s_unmapped_rd |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
  AST_FIFO_FILL: assert property (
    s_fill_f0 |=> !fifo_empty[0]) else $error("input fifo write lost");
  AST_PLA_COMB: assert property (
    pla0_or_sel == '0 && pla0_reg_sel == '0 |-> pla0_out == '0)
    else $error("empty sum not zero");
  AST_PLA_REG: assert property (
    $past(pla0_or_sel) == '0 && pla0_reg_sel == 4'hf |-> pla0_out == '0)
    else $error("registered empty sum not zero");
  AST_PLA1_COMB: assert property (
    pla1_or_sel == '0 && pla1_reg_sel == '0 |-> pla1_out == '0)
    else $error("second array empty sum not zero");
endmodule
bind plc_cell plc_cell_props u_props (.clk, .rst_b, .bus_addr, .bus_wr, .bus_rd, .bus_rdata,
  .fifo_dir_in, .cond_en, .cond_out, .fifo_empty, .fifo_full, .pla0_or_sel, .pla0_reg_sel,
  .pla0_out, .pla1_or_sel, .pla1_reg_sel, .pla1_out);

// >>> bench/plc_route_model.sv
// Bus master and routing stand-in on the far side of the cell.
`timescale 1ns/100ps
module plc_route_model import plc_pkg::*; (
  input wire logic clk,
  input wire logic [plc_pkg::DW-1:0] bus_rdata,
  output logic [4:0] bus_addr,
  output logic bus_wr,
  output logic bus_rd,
  output logic [plc_pkg::DW-1:0] bus_wdata,
  output logic [2:0] cfg_addr
);
  initial begin
    bus_addr = 5'h1f;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 8'h00;
    cfg_addr = 3'h0;
  end
  // Released lines show the inverse of the last value.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    bus_addr <= ~a;
    #1;
    d = bus_rdata;
  endtask
  task automatic cfgw(input logic [2:0] i, input logic [15:0] w);
    wr(OFS_CFG_BASE + {1'b0, i, 1'b0}, w[7:0]);
    wr(OFS_CFG_BASE + {1'b0, i, 1'b1}, w[15:8]);
  endtask
  task automatic run(input logic [2:0] i, input int n);
    @(posedge clk);
    cfg_addr <= i;
    repeat (n) @(posedge clk);
    cfg_addr <= 3'h0;
  endtask
endmodule

// >>> bench/plc_cell_tb.sv
// Self-checking bench for the programmable logic cell.
`timescale 1ns/100ps
module plc_cell_tb;
  import plc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] bus_addr;
  logic bus_wr, bus_rd;
  logic [7:0] bus_wdata, bus_rdata;
  logic [2:0] cfg_addr;
  logic [1:0] fifo_dir_in = 2'h1, fifo_src_acc = 2'h2, cmp0_sel = 2'h0, cmp1_sel = 2'h1;
  logic [7:0] cmp0_mask = 8'hff, cmp1_mask = 8'hff, or_mask = 8'h00, crc_poly = 8'h00;
  logic [2:0] msb_sel = 3'h7;
  logic [8:0] cond_en = 9'h1ff, cond_out;
  logic chain_en = 1'b0, shift_in = 1'b0, chain_eq_in = 1'b0, chain_lt_in = 1'b0;
  logic chain_carry_in = 1'b0, chain_fb_in = 1'b0;
  logic chain_eq_out, chain_lt_out, chain_carry_out, chain_fb_out, shift_out;
  logic [1:0] fifo_empty, fifo_full;
  logic [11:0] pla0_in = 12'h000;
  logic [95:0] pla0_pt_true = '0, pla0_pt_comp = '0;
  logic [31:0] pla0_or_sel = '0;
  logic [3:0] pla0_reg_sel = 4'h0, pla0_out, pla1_out;
  int failures = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  plc_route_model mdl (.clk, .bus_rdata, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .cfg_addr);
  plc_cell dut (.clk, .rst_b, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .cfg_addr,
    .fifo_dir_in, .fifo_src_acc, .cmp0_sel, .cmp1_sel, .cmp0_mask, .cmp1_mask, .msb_sel,
    .or_mask, .crc_poly, .cond_en, .chain_en, .shift_in, .chain_eq_in, .chain_lt_in,
    .chain_carry_in, .chain_fb_in, .cond_out, .chain_eq_out, .chain_lt_out, .chain_carry_out,
    .chain_fb_out, .shift_out, .fifo_empty, .fifo_full, .pla0_in, .pla0_pt_true, .pla0_pt_comp,
    .pla0_or_sel, .pla0_reg_sel, .pla0_out, .pla1_in(pla0_in), .pla1_pt_true(pla0_pt_true),
    .pla1_pt_comp(pla0_pt_comp), .pla1_or_sel(pla0_or_sel), .pla1_reg_sel(pla0_reg_sel),
    .pla1_out);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [15:0] w, input logic [7:0] a, output logic [7:0] r);
    mdl.cfgw(3'h1, w);
    mdl.wr(OFS_ACC0, a);
    mdl.run(3'h1, 1);
    mdl.rd(OFS_ACC0, r);
  endtask
  task automatic t_regs;
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      mdl.rd(5'(i), r);
      chk(r, 8'h00);
      mdl.wr(5'(i), 8'ha4 + 8'(i));
    end
    for (int i = 0; i < 4; i++) begin
      mdl.rd(5'(i), r);
      chk(r, 8'ha4 + 8'(i));
    end
    mdl.rd(5'h08, r);
    chk(r, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_alu;
    logic [7:0] r, e;
    logic [2:0] fn;
    mdl.wr(OFS_DAT0, 8'h3c);
    for (int f = 0; f < 8; f++) begin
      fn = 3'(f);
      case (fn)
        FN_PASS: e = 8'hc5;
        FN_INC: e = 8'hc6;
        FN_DEC: e = 8'hc4;
        FN_ADD: e = 8'h01;
        FN_SUB: e = 8'h89;
        FN_XOR: e = 8'hf9;
        FN_AND: e = 8'h04;
        default: e = 8'hfd;
      endcase
      op({5'h00, DS_ACC0, SH_NONE, 2'h2, 2'h0, fn}, 8'hc5, r);
      chk(r, e);
    end
    mdl.rd(OFS_DAT0, r);
    chk(r, 8'h3c);
    $display("test alu done");
  endtask
  task automatic t_shift;
    logic [7:0] r;
    logic [7:0] ex [3] = '{8'h2c, 8'h4b, 8'h69};
    for (int s = 1; s < 4; s++) begin
      op({5'h00, DS_ACC0, 2'(s), 2'h0, 2'h0, FN_PASS}, 8'h96, r);
      chk(r, ex[s-1]);
    end
    @(posedge clk);
    or_mask <= 8'h01;
    op({5'h00, DS_ACC0, SH_NONE, 2'h0, 2'h0, FN_PASS}, 8'h96, r);
    chk(r, 8'h97);
    or_mask <= 8'h00;
    msb_sel <= 3'h3;
    op({5'h00, DS_ACC0, SH_NONE, 2'h0, 2'h0, FN_INC}, 8'hf7, r);
    chk(r, 8'h08);
    chk(16'({chain_eq_out, chain_lt_out, chain_carry_out, chain_fb_out, shift_out}),
      16'ha);
    msb_sel <= 3'h7;
    crc_poly <= 8'h07;
    op(16'h0a00, 8'h81, r);
    chk(r, 8'h05);
    chain_en <= 1'b1;
    chain_carry_in <= 1'b1;
    op({5'h00, DS_ACC0, SH_NONE, 2'h2, 2'h0, FN_ADD}, 8'h01, r);
    chk(r, 8'h3e);
    chain_en <= 1'b0;
    $display("test shift done");
  endtask
  task automatic t_cond;
    mdl.wr(OFS_ACC0, 8'h00);
    mdl.wr(OFS_DAT0, 8'h00);
    mdl.wr(OFS_ACC1, 8'hff);
    mdl.wr(OFS_DAT1, 8'hff);
    repeat (3) @(posedge clk);
    #1 chk(16'(cond_out), 16'h0095);
    cmp0_mask <= 8'hfe;
    mdl.wr(OFS_DAT0, 8'h01);
    repeat (3) @(posedge clk);
    #1 chk(16'(cond_out), 16'h0095);
    cond_en <= 9'h0f0;
    repeat (3) @(posedge clk);
    #1 chk(16'(cond_out), 16'h0090);
    cond_en <= 9'h1ff;
    $display("test cond done");
  endtask
  task automatic t_fifo;
    logic [7:0] r;
    chk(16'(fifo_empty), 16'h3);
    for (int k = 1; k < 6; k++) mdl.wr(OFS_FIFO0, 8'(k * 17));
    #1 chk(16'(fifo_full), 16'h1);
    mdl.cfgw(3'h2, 16'h4000);
    mdl.run(3'h2, 1);
    mdl.rd(OFS_DAT0, r);
    chk(r, 8'h11);
    mdl.run(3'h2, 3);
    mdl.rd(OFS_DAT0, r);
    chk(r, 8'h44);
    chk(16'(fifo_empty), 16'h3);
    mdl.wr(OFS_ACC1, 8'h7e);
    mdl.cfgw(3'h3, 16'h2000);
    mdl.run(3'h3, 1);
    mdl.rd(OFS_FIFO1, r);
    chk(r, 8'h7e);
    mdl.rd(OFS_FIFO1, r);
    chk(r, 8'h00);
    $display("test fifo done");
  endtask
  task automatic t_pla;
    logic [2:0] v;
    @(posedge clk);
    pla0_pt_true <= 96'h3;
    pla0_pt_comp <= 96'h4000;
    pla0_or_sel <= 32'h0003_0201;
    pla0_reg_sel <= 4'h2;
    for (int k = 0; k < 8; k++) begin
      v = 3'(k);
      @(posedge clk);
      pla0_in <= {9'h000, v};
      @(posedge clk);
      #1 chk(pla0_out, {1'b0, (v[0] & v[1]) | ~v[2], ~v[2], v[0] & v[1]});
      chk(pla1_out, {1'b0, (v[0] & v[1]) | ~v[2], ~v[2], v[0] & v[1]});
    end
    pla0_or_sel <= '0;
    pla0_reg_sel <= 4'hf;
    repeat (3) @(posedge clk);
    $display("test pla done");
  endtask
  task automatic report_and_stop;
    $display("compares=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #500000;
    failures++;
    report_and_stop;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_fifo;
    t_alu;
    t_shift;
    t_cond;
    t_pla;
    report_and_stop;
  end
endmodule
